// File: rtl/pic_params.svh
// Constants for the prioritising interrupt controller.
// Assumes one 100 MHz clock and APB byte addresses in the low 8 bits.
`ifndef PIC_PARAMS_SVH
`define PIC_PARAMS_SVH
`define PIC_NSRC 80
`define PIC_NIPC 17
`define PIC_FIRST_VEC 7'h08
`define PIC_IVT_BASE 24'h000004
`define PIC_ALT_OFS 24'h000100
`define PIC_RESV_MASK 80'h3181_19FF_9FE0_0020_8000
`define PIC_EXT1_POS 20
`define PIC_EXT2_POS 29
`define PIC_CON1_OFS 8'h00
`define PIC_CON2_OFS 8'h04
`define PIC_IFS_OFS 8'h10
`define PIC_IEC_OFS 8'h30
`define PIC_IPC_OFS 8'h50
`define PIC_PEND_OFS 8'hA0
`define PIC_SR_OFS 8'hC0
`define PIC_CORE_OFS 8'hC4
`define PIC_CON1_MASK 16'hFFFE
`define PIC_CON2_MASK 16'h8007
`define PIC_CORE_MASK 16'h1FF7
`define PIC_CORE_RST 16'h0020
`define PIC_NEST_BIT 15
`define PIC_ALT_BIT 15
`define PIC_DISI_BIT 14
`define PIC_TOP_BIT 3
`define PIC_IPL_LSB 5
`define PIC_LEVEL_USER_MAX 4'h7
`endif

// File: rtl/pic_pkg.sv
// Types shared by the interrupt controller and its surroundings.
// Assumes the constants header is on the include path.
package pic_pkg;
  typedef struct packed {
    logic oscFail;
    logic stackErr;
    logic addrErr;
    logic dmaErr;
    logic divZero;
    logic shiftErr;
    logic accBCat;
    logic accACat;
    logic accBOvf;
    logic accAOvf;
  } pic_trap_s;

  typedef struct packed {
    logic irqAck;
    logic trapExit;
    logic disiActive;
  } pic_core_s;

  typedef struct packed {
    logic reqValid;
    logic [6:0] vecNum;
    logic [3:0] level;
    logic [23:0] vecAddr;
  } pic_pend_s;
endpackage : pic_pkg

// File: rtl/pic_ctrl.sv
// Prioritising interrupt controller with APB register access.
// Assumes source pulses and pins are synchronous to ref_clk.
`timescale 1ns/1ns
`include "pic_params.svh"
module pic_ctrl
  import pic_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [`PIC_NSRC-1:0] srcReq,
  input wire logic [2:0] extReq,
  input wire pic_trap_s trapEv,
  input wire pic_core_s coreIn,
  output pic_pend_s pendOut,
  output logic [3:0] cpuLevel,
  output logic altTable
);
  localparam int NSRC = `PIC_NSRC;
  localparam logic [NSRC-1:0] RESV = `PIC_RESV_MASK;

  logic pready_q;
  logic pslverr_q;
  logic [31:0] prdata_q;
  logic [NSRC-1:0] flag_q;
  logic [NSRC-1:0] enable_q;
  logic [2:0] prio_q [NSRC];
  logic [15:0] con1_q;
  logic [15:0] con2_q;
  logic [15:0] core_q;
  logic [2:0] iplLow_q;
  logic iplTop_q;
  logic [2:0] extPrev_q;
  pic_pend_s pend_q;

  function automatic logic regHit(input logic [7:0] a,
                                  input logic [7:0] base, input int idx);
    regHit = (a == base + 8'(idx * 4));
  endfunction : regHit

  // Three of the twenty priority groups hold only reserved slots
  function automatic int ipcGroup(input int k);
    if (k < 10)
      ipcGroup = k;
    else if (k == 10)
      ipcGroup = 11;
    else
      ipcGroup = k + 3;
  endfunction : ipcGroup

  logic wrEn;
  logic rdEn;
  assign wrEn = psel & penable & pready_q & pwrite;
  assign rdEn = psel & penable & ~pready_q;

  // APB slave: one wait state, answer data taken from flops
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn)
      pready_q <= 1'b0;
    else
      pready_q <= psel & penable & ~pready_q;
  end

  logic [31:0] rdData;
  logic rdErr;
  always_comb begin
    rdData = 32'h0000_0000;
    rdErr = 1'b1;
    if (regHit(paddr, `PIC_CON1_OFS, 0)) begin
      rdData[15:0] = con1_q;
      rdErr = 1'b0;
    end
    if (regHit(paddr, `PIC_CON2_OFS, 0)) begin
      rdData[15:0] = con2_q;
      rdErr = 1'b0;
    end
    for (int w = 0; w < NSRC / 16; w++) begin
      if (regHit(paddr, `PIC_IFS_OFS, w)) begin
        rdData[15:0] = flag_q[w*16 +: 16];
        rdErr = 1'b0;
      end
      if (regHit(paddr, `PIC_IEC_OFS, w)) begin
        rdData[15:0] = enable_q[w*16 +: 16];
        rdErr = 1'b0;
      end
    end
    for (int k = 0; k < `PIC_NIPC; k++) begin
      if (regHit(paddr, `PIC_IPC_OFS, k)) begin
        for (int j = 0; j < 4; j++)
          rdData[j*4 +: 3] = prio_q[ipcGroup(k)*4 + j];
        rdErr = 1'b0;
      end
    end
    if (regHit(paddr, `PIC_PEND_OFS, 0)) begin
      rdData[6:0] = pend_q.vecNum;
      rdData[11:8] = pend_q.level;
      rdErr = 1'b0;
    end
    if (regHit(paddr, `PIC_SR_OFS, 0)) begin
      rdData[`PIC_IPL_LSB +: 3] = iplLow_q;
      rdErr = 1'b0;
    end
    if (regHit(paddr, `PIC_CORE_OFS, 0)) begin
      rdData[15:0] = core_q;
      rdData[`PIC_TOP_BIT] = iplTop_q;
      rdErr = 1'b0;
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      prdata_q <= 32'h0000_0000;
      pslverr_q <= 1'b0;
    end else begin
      prdata_q <= rdEn ? rdData : 32'h0000_0000;
      pslverr_q <= rdEn & rdErr;
    end
  end

  // External request edges, polarity from control two bits 2:0
  logic [2:0] extEdge;
  always_comb begin
    for (int e = 0; e < 3; e++)
      extEdge[e] = con2_q[e] ? (extPrev_q[e] & ~extReq[e])
                             : (~extPrev_q[e] & extReq[e]);
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn)
      extPrev_q <= 3'h0;
    else
      extPrev_q <= extReq;
  end

  logic [NSRC-1:0] srcSet;
  always_comb begin
    srcSet = srcReq;
    srcSet[0] = srcReq[0] | extEdge[0];
    srcSet[`PIC_EXT1_POS] = srcReq[`PIC_EXT1_POS] | extEdge[1];
    srcSet[`PIC_EXT2_POS] = srcReq[`PIC_EXT2_POS] | extEdge[2];
  end

  // Flag and enable words written as whole 16-bit registers
  logic [NSRC-1:0] flagBase;
  logic [NSRC-1:0] enableNext;
  always_comb begin
    flagBase = flag_q;
    enableNext = enable_q;
    for (int w = 0; w < NSRC / 16; w++) begin
      if (wrEn && regHit(paddr, `PIC_IFS_OFS, w))
        flagBase[w*16 +: 16] = pwdata[15:0];
      if (wrEn && regHit(paddr, `PIC_IEC_OFS, w))
        enableNext[w*16 +: 16] = pwdata[15:0];
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn)
      flag_q <= '0;
    else
      flag_q <= (flagBase | srcSet) & ~RESV;
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn)
      enable_q <= '0;
    else
      enable_q <= enableNext & ~RESV;
  end

  // Priority fields, four per register in natural order
  genvar gk, gj;
  generate
    for (gk = 0; gk < `PIC_NIPC; gk++) begin : gIpc
      for (gj = 0; gj < 4; gj++) begin : gFld
        localparam int SI = ipcGroup(gk) * 4 + gj;
        always_ff @(posedge ref_clk or negedge rstn) begin
          if (!rstn)
            prio_q[SI] <= 3'h0;
          else if (RESV[SI])
            prio_q[SI] <= 3'h0;
          else if (wrEn && regHit(paddr, `PIC_IPC_OFS, gk))
            prio_q[SI] <= pwdata[gj*4 +: 3];
        end
      end
    end
    for (gk = 40; gk < 56; gk++) begin : gGap
      if (gk < 44 || gk > 47) begin : gRes
        always_ff @(posedge ref_clk or negedge rstn) begin
          if (!rstn)
            prio_q[gk] <= 3'h0;
          else
            prio_q[gk] <= 3'h0;
        end
      end
    end
  endgenerate

  // Trap flags; a math trap is any enabled accumulator cause, or a shift or divide cause
  logic ovaTrap;
  logic ovbTrap;
  logic covaTrap;
  logic covbTrap;
  logic mathTrap;
  logic anyTrap;
  logic [15:0] con1Set;
  assign ovaTrap = trapEv.accAOvf & con1_q[10];
  assign ovbTrap = trapEv.accBOvf & con1_q[9];
  assign covaTrap = trapEv.accACat & con1_q[8];
  assign covbTrap = trapEv.accBCat & con1_q[8];
  assign mathTrap = ovaTrap | ovbTrap | covaTrap | covbTrap |
                    trapEv.shiftErr | trapEv.divZero;
  assign anyTrap = mathTrap | trapEv.dmaErr | trapEv.addrErr |
                   trapEv.stackErr | trapEv.oscFail;

  always_comb begin
    con1Set = 16'h0000;
    con1Set[14] = ovaTrap;
    con1Set[13] = ovbTrap;
    con1Set[12] = covaTrap;
    con1Set[11] = covbTrap;
    con1Set[7] = trapEv.shiftErr;
    con1Set[6] = trapEv.divZero;
    con1Set[5] = trapEv.dmaErr;
    con1Set[4] = mathTrap;
    con1Set[3] = trapEv.addrErr;
    con1Set[2] = trapEv.stackErr;
    con1Set[1] = trapEv.oscFail;
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn)
      con1_q <= 16'h0000;
    else if (wrEn && regHit(paddr, `PIC_CON1_OFS, 0))
      con1_q <= (pwdata[15:0] | con1Set) & `PIC_CON1_MASK;
    else
      con1_q <= con1_q | con1Set;
  end

  // Control two: table select, live block-status bit, edge polarities
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn)
      con2_q <= 16'h0000;
    else begin
      if (wrEn && regHit(paddr, `PIC_CON2_OFS, 0))
        con2_q <= pwdata[15:0] & `PIC_CON2_MASK;
      else
        con2_q <= con2_q & `PIC_CON2_MASK;
      con2_q[`PIC_DISI_BIT] <= coreIn.disiActive;
    end
  end

  // Top level bit: set by trap entry, ended only by the core
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn)
      iplTop_q <= 1'b0;
    else if (anyTrap)
      iplTop_q <= 1'b1;
    else if (coreIn.trapExit)
      iplTop_q <= 1'b0;
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn)
      core_q <= `PIC_CORE_RST;
    else if (wrEn && regHit(paddr, `PIC_CORE_OFS, 0))
      core_q <= pwdata[15:0] & `PIC_CORE_MASK;
  end

  // Acknowledge raises the level; nesting disabled forces level 7
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn)
      iplLow_q <= 3'h0;
    else if (coreIn.irqAck && pend_q.reqValid)
      iplLow_q <= con1_q[`PIC_NEST_BIT] ? 3'h7 : pend_q.level[2:0];
    else if (wrEn && regHit(paddr, `PIC_SR_OFS, 0) &&
             !con1_q[`PIC_NEST_BIT])
      iplLow_q <= pwdata[`PIC_IPL_LSB +: 3];
  end

  logic [3:0] curLevel;
  assign curLevel = {iplTop_q, iplLow_q};

  // Scan from the top so that ties fall to the lower vector
  logic found;
  logic [2:0] bestP;
  logic [6:0] bestI;
  always_comb begin
    found = 1'b0;
    bestP = 3'h0;
    bestI = 7'h00;
    for (int i = NSRC - 1; i >= 0; i--) begin
      if (flag_q[i] && enable_q[i] && !RESV[i] &&
          {1'b0, prio_q[i]} > curLevel && prio_q[i] >= bestP) begin
        found = 1'b1;
        bestP = prio_q[i];
        bestI = 7'(i);
      end
    end
  end

  logic [6:0] winVec;
  logic [23:0] winAddr;
  assign winVec = bestI + `PIC_FIRST_VEC;
  assign winAddr = `PIC_IVT_BASE + 24'({winVec, 1'b0}) +
                   (con2_q[`PIC_ALT_BIT] ? `PIC_ALT_OFS : 24'h000000);

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn)
      pend_q <= '0;
    else begin
      pend_q.reqValid <= found;
      pend_q.vecNum <= found ? winVec : 7'h00;
      pend_q.level <= found ? {1'b0, bestP} : 4'h0;
      pend_q.vecAddr <= found ? winAddr : 24'h000000;
    end
  end

  // Level and table outputs registered so they come from flops
  logic [3:0] cpuLevel_q;
  logic altTable_q;
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      cpuLevel_q <= 4'h0;
      altTable_q <= 1'b0;
    end else begin
      cpuLevel_q <= curLevel;
      altTable_q <= con2_q[`PIC_ALT_BIT];
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign pendOut = pend_q;
  assign cpuLevel = cpuLevel_q;
  assign altTable = altTable_q;

  logic wrIfs0;
  logic wrSr;
  logic wrCore;
  assign wrIfs0 = wrEn && regHit(paddr, `PIC_IFS_OFS, 0);
  assign wrSr = wrEn && regHit(paddr, `PIC_SR_OFS, 0);
  assign wrCore = wrEn && regHit(paddr, `PIC_CORE_OFS, 0);

  sequence sMathCause;
    trapEv.shiftErr;
  endsequence
  sequence sMathFlags;
    con1_q[7] && con1_q[4];
  endsequence

  a_flag_sticky: assert property (@(posedge ref_clk)
    disable iff (!rstn) flag_q[0] && !wrIfs0 |=> flag_q[0])
    else $error("flag cleared without a software write");
  a_set_wins: assert property (@(posedge ref_clk)
    disable iff (!rstn) srcReq[1] && wrIfs0 && !pwdata[1] |=> flag_q[1])
    else $error("set lost against a clearing write");
  a_gate_off: assert property (@(posedge ref_clk)
    disable iff (!rstn) (flag_q & enable_q) == '0 |=> !pend_q.reqValid)
    else $error("request without an enabled flag");
  a_level_match: assert property (@(posedge ref_clk)
    disable iff (!rstn) pend_q.reqValid |-> pend_q.level[3] == 1'b0 &&
      pend_q.level != 4'h0 && pend_q.vecNum >= `PIC_FIRST_VEC)
    else $error("pending level or vector out of range");
  a_beats_level: assert property (@(posedge ref_clk)
    disable iff (!rstn) iplTop_q || iplLow_q == 3'h7 |=> !pend_q.reqValid)
    else $error("user request while CPU level masks it");
  a_resv_zero: assert property (@(posedge ref_clk)
    disable iff (!rstn) ((flag_q | enable_q) & RESV) == '0)
    else $error("reserved position holds a bit");
  a_vec_addr: assert property (@(posedge ref_clk)
    disable iff (!rstn) pend_q.reqValid |-> pend_q.vecAddr == `PIC_IVT_BASE +
      24'({pend_q.vecNum, 1'b0}) + (altTable_q ? `PIC_ALT_OFS : 24'h0))
    else $error("vector address not in selected table");
  a_top_ro: assert property (@(posedge ref_clk)
    disable iff (!rstn)
      wrCore && !anyTrap && !coreIn.trapExit |=> $stable(iplTop_q))
    else $error("software changed the top level bit");
  a_nest_lock: assert property (@(posedge ref_clk)
    disable iff (!rstn) con1_q[`PIC_NEST_BIT] && wrSr && !coreIn.irqAck
      |=> $stable(iplLow_q))
    else $error("low level bits written under nesting disable");
  a_math_flag: assert property (@(posedge ref_clk)
    disable iff (!rstn) sMathCause |=> sMathFlags)
    else $error("shift trap not flagged");
  a_div_flag: assert property (@(posedge ref_clk)
    disable iff (!rstn) trapEv.divZero |=> con1_q[6] && con1_q[4])
    else $error("divide trap not flagged");
  a_apb_answer: assert property (@(posedge ref_clk)
    disable iff (!rstn) psel && penable && !pready_q |=> pready_q)
    else $error("APB answer late");
endmodule : pic_ctrl

// File: verification/pic_core_model.sv
// Behavioural processor core facing the interrupt controller.
// Assumes the bench asks for each acknowledge and each trap return.
`timescale 1ns/1ns
module pic_core_model
  import pic_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rstn,
  input wire pic_pend_s pendIn,
  input wire logic ackReq,
  input wire logic [3:0] ackWait,
  input wire logic exitReq,
  input wire logic disiIn,
  output pic_core_s coreOut
);
  logic armed_q;
  logic [3:0] waitCnt_q;

  // Delay lets the bench mimic a core that is slow to take a request
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      armed_q <= 1'h0;
      waitCnt_q <= 4'h0;
      coreOut <= '0;
    end else begin
      coreOut.irqAck <= 1'h0;
      coreOut.trapExit <= exitReq;
      coreOut.disiActive <= disiIn;
      if (ackReq) begin
        armed_q <= 1'h1;
        waitCnt_q <= ackWait;
      end else if (armed_q && pendIn.reqValid) begin
        if (waitCnt_q == 4'h0) begin
          coreOut.irqAck <= 1'h1;
          armed_q <= 1'h0;
        end else begin
          waitCnt_q <= waitCnt_q - 4'h1;
        end
      end
    end
  end
endmodule : pic_core_model

// File: verification/test_priority_interrupt_controller.sv
// Self-checking bench for the prioritising interrupt controller.
// Assumes the core model answers acknowledges; APB is driven here.
`timescale 1ns/1ns
`include "pic_params.svh"
module test_priority_interrupt_controller
  import pic_pkg::*;
;
  logic ref_clk = 1'h0;
  logic rstn = 1'h0;
  logic psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata;
  logic pready, pslverr, altTable;
  logic [`PIC_NSRC-1:0] srcReq = '0;
  logic [2:0] extReq = 3'h0;
  pic_trap_s trapEv = '0;
  pic_core_s coreIn;
  pic_pend_s pendOut;
  logic [3:0] cpuLevel;
  logic ackReq = 1'h0, exitReq = 1'h0, disi = 1'h0;
  logic [3:0] ackWait = 4'h0;
  logic [79:0] mFlag = '0, mEn = '0, resv = `PIC_RESV_MASK;
  int mPri[80] = '{default: 0};
  int mLow = 0, mTop = 0, mAlt = 0, mNest = 0;
  int bitOf[6] = '{14, 13, 12, 11, 7, 6};
  int bad_count = 0, check_count = 0;
  logic [31:0] seed = 32'hEF78;

  always #5 ref_clk = ~ref_clk;

  pic_ctrl i_dut (.ref_clk(ref_clk), .rstn(rstn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .srcReq(srcReq),
    .extReq(extReq), .trapEv(trapEv), .coreIn(coreIn), .pendOut(pendOut),
    .cpuLevel(cpuLevel), .altTable(altTable));
  pic_core_model i_core (.ref_clk(ref_clk), .rstn(rstn), .pendIn(pendOut),
    .ackReq(ackReq), .ackWait(ackWait), .exitReq(exitReq), .disiIn(disi),
    .coreOut(coreIn));

  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs

  // Winner: highest priority above CPU level, lowest order on a tie
  function automatic logic [35:0] expPend();
    int b;
    int lv;
    b = -1;
    lv = mTop * 8 + mLow;
    for (int i = 0; i < 80; i++)
      if (!resv[i] && mFlag[i] && mEn[i] && mPri[i] > lv &&
          (b < 0 || mPri[i] > mPri[b])) b = i;
    if (b < 0) return '0;
    return {1'h1, 7'(b + 8), 4'(mPri[b]), 24'(4 + 2 * (b + 8) + mAlt * 256)};
  endfunction : expPend

  function automatic logic [31:0] fw(input int w);
    return 32'(mFlag[16*w+:16] & ~resv[16*w+:16]);
  endfunction : fw

  task automatic results();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : results

  task automatic chk(input string n, input logic [35:0] e,
                     input logic [35:0] g);
    check_count++;
    if (g !== e) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  // Request held until pready is sampled high, then released
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] r,
                     output logic e);
    int n;
    @(posedge ref_clk);
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'h1;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (pready !== 1'h1 && n < 20);
    if (pready !== 1'h1) bad_count++;
    r = prdata;
    e = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'h1, a, d, r, e);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    logic [31:0] r;
    logic e;
    apb(1'h0, a, 32'h0, r, e);
    chk("prdata", {4'h0, x}, {4'h0, r});
    chk("pslverr", 36'h0, {35'h0, e});
  endtask : rd

  task automatic look();
    repeat (5) @(posedge ref_clk);
    @(negedge ref_clk);
    chk("pendOut", expPend(), pendOut);
    chk("cpuLevel", 36'(mTop * 8 + mLow), {32'h0, cpuLevel});
    chk("altTable", 36'(mAlt), {35'h0, altTable});
  endtask : look

  task automatic setPri(input int s, input int p);
    int g;
    int k;
    mPri[s] = p;
    g = s / 4;
    k = g < 10 ? g : (g == 11 ? 10 : g - 3);
    wr(8'(80 + 4 * k), 32'(mPri[4*g] | mPri[4*g+1] << 4 |
       mPri[4*g+2] << 8 | mPri[4*g+3] << 12));
  endtask : setPri

  task automatic pulse(input int s);
    @(posedge ref_clk);
    srcReq[s] <= 1'h1;
    @(posedge ref_clk);
    srcReq <= '0;
    mFlag[s] = 1'h1;
  endtask : pulse

  task automatic setSr(input int v);
    wr(8'hC0, 32'(v << 5));
    if (mNest == 0) mLow = v;
  endtask : setSr

  task automatic ack(input logic [3:0] dly);
    logic [35:0] p;
    p = expPend();
    @(posedge ref_clk);
    ackWait <= dly;
    ackReq <= 1'h1;
    @(posedge ref_clk);
    ackReq <= 1'h0;
    repeat (12) @(posedge ref_clk);
    mLow = mNest ? 7 : int'(p[26:24]);
  endtask : ack

  task automatic trap(input int t);
    @(posedge ref_clk);
    trapEv <= pic_trap_s'(10'h1 << t);
    @(posedge ref_clk);
    trapEv <= '0;
    mTop = 1;
  endtask : trap

  task automatic exitT();
    @(posedge ref_clk);
    exitReq <= 1'h1;
    @(posedge ref_clk);
    exitReq <= 1'h0;
    mTop = 0;
  endtask : exitT

  initial begin
    repeat (60000) @(posedge ref_clk);
    bad_count++;
    results();
  end

  initial begin
    logic [31:0] r, d;
    logic e;
    repeat (5) @(posedge ref_clk);
    rstn <= 1'h1;
    look();
    rd(8'hC4, 32'h20);
    rd(8'hC0, 32'h0);
    rd(8'h00, 32'h0);
    for (int k = 0; k < 30; k++) begin
      apb(1'h0, 8'(k < 2 ? 4 * k : k < 7 ? 8 + 4 * k : k < 12 ? 20 + 4 * k :
          k < 29 ? 32 + 4 * k : 160), 32'h0, r, e);
      chk("pslverr", 36'h0, {35'h0, e});
    end
    apb(1'h0, 8'hFC, 32'h0, r, e);
    chk("pslverr", 36'h1, {35'h0, e});
    chk("prdata", 36'h0, {4'h0, r});
    for (int w = 0; w < 5; w++) begin
      d = xs() & 32'hFFFF;
      wr(8'(48 + 4 * w), d);
      rd(8'(48 + 4 * w), d & 32'(~resv[16*w+:16]));
      wr(8'(48 + 4 * w), 32'hFFFF);
      mEn[16*w+:16] = 16'hFFFF;
    end
    setPri(0, 3);
    pulse(0);
    look();
    setPri(78, 5);
    setPri(79, 5);
    pulse(79);
    pulse(78);
    pulse(71);
    look();
    rd(8'h20, fw(4));
    setPri(57, 6);
    pulse(57);
    look();
    wr(8'h04, 32'h8000);
    mAlt = 1;
    look();
    wr(8'h04, 32'h0);
    mAlt = 0;
    setSr(6);
    look();
    setSr(7);
    look();
    setSr(0);
    ack(4'h3);
    look();
    rd(8'hC0, 32'hC0);
    rd(8'h1C, fw(3));
    setSr(4);
    look();
    wr(8'h00, 32'h8000);
    mNest = 1;
    setSr(0);
    look();
    rd(8'hC0, 32'h80);
    ack(4'h0);
    look();
    rd(8'hC0, 32'hE0);
    wr(8'h00, 32'h0);
    mNest = 0;
    setSr(0);
    look();
    for (int w = 0; w < 5; w++) wr(8'(16 + 4 * w), 32'h0);
    mFlag = '0;
    look();
    @(posedge ref_clk);
    extReq <= 3'h7;
    mFlag[0] = 1'h1;
    mFlag[20] = 1'h1;
    mFlag[29] = 1'h1;
    look();
    rd(8'h14, fw(1));
    wr(8'h10, 32'h0);
    wr(8'h14, 32'h0);
    wr(8'h04, 32'h7);
    @(posedge ref_clk);
    extReq <= 3'h0;
    look();
    rd(8'h10, fw(0));
    rd(8'h14, fw(1));
    wr(8'h14, 32'h0);
    wr(8'h04, 32'h0);
    // Source held high across a clearing write: the set must win
    @(posedge ref_clk);
    srcReq[1] <= 1'h1;
    wr(8'h10, 32'h0);
    srcReq[1] <= 1'h0;
    mFlag = '0;
    mFlag[1] = 1'h1;
    rd(8'h10, fw(0));
    wr(8'h10, 32'h0);
    mFlag = '0;
    @(posedge ref_clk);
    disi <= 1'h1;
    repeat (2) @(posedge ref_clk);
    rd(8'h04, 32'h4000);
    disi <= 1'h0;
    wr(8'hC4, 32'h0);
    wr(8'hC4, 32'h8);
    rd(8'hC4, 32'h0);
    wr(8'h00, 32'h0700);
    for (int t = 0; t < 6; t++) begin
      trap(t);
      look();
      rd(8'h00, 32'h0710 | 32'h1 << bitOf[t]);
      rd(8'hC4, 32'h8);
      wr(8'h00, 32'h0700);
      exitT();
      look();
      rd(8'hC4, 32'h0);
    end
    wr(8'h00, 32'h0);
    trap(0);
    rd(8'h00, 32'h0);
    exitT();
    look();
    results();
  end
endmodule : test_priority_interrupt_controller
